// >>> amp_prot_pkg.sv
// Constants and types shared by the amplifier protection sequencer.
package amp_prot_pkg;
    // Clock and interval figures in their own units.
    localparam int CLK_KHZ = 125000;
    localparam int RESTART_MS = 100;
    localparam int CARRIER_KHZ = 335;
    localparam int FOLD_STEP_US = 100;
    // Derived cycle counts at the core clock rate.
    localparam int RESTART_CYC = RESTART_MS * CLK_KHZ;
    localparam int CARRIER_CYC = CLK_KHZ / CARRIER_KHZ;
    localparam int FOLD_STEP_CYC = (FOLD_STEP_US * CLK_KHZ) / 1000;
    localparam int TMR_W = 24;
    localparam int PH_W = 12;
    localparam int NUM_SWITCHES = 4;
    // Gain reduction in half-decibel steps; twelve steps make 6 dB.
    localparam logic [3:0] ATTEN_MAX = 4'hc;
    localparam logic [3:0] ATTEN_ZERO = 4'h0;
    // Positions of the synchronised comparator and pin inputs.
    localparam int IX_WSET = 0;
    localparam int IX_WCLR = 1;
    localparam int IX_FOLD = 2;
    localparam int IX_SHUT = 3;
    localparam int IX_LOWZ = 4;
    localparam int IX_CAPE = 5;
    localparam int IX_WPIN = 6;
    localparam int IX_FPIN = 7;
    localparam int IX_OC = 8;
    // Register map.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_FOLD_DIS = 2;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_WARN = 3;
    localparam int STAT_FOLD = 4;
    localparam int STAT_LIMIT = 5;
    localparam int STAT_DISCH = 6;
    localparam int STAT_ATTEN_LSB = 8;
    localparam int STAT_WPIN = 12;
    localparam int STAT_FPIN = 13;
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_MUTE = 2'b01,
        MODE_OPERATE = 2'b10,
        MODE_SPARE = 2'b11
    } mode_t;
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_STARTUP = 3'b001,
        ST_RUN = 3'b010,
        ST_OT_OFF = 3'b011,
        ST_OC_OFF = 3'b100
    } fsm_t;
endpackage

// >>> amp_prot_seq.sv
// Fault-response and diagnostic sequencer for a two-channel class-D amplifier.
`timescale 1ns/100ps
module amp_prot_seq #(
    parameter int RESTART_CYCLES = amp_prot_pkg::RESTART_CYC,
    parameter int FOLD_STEP_CYCLES = amp_prot_pkg::FOLD_STEP_CYC,
    parameter int CARRIER_CYCLES = amp_prot_pkg::CARRIER_CYC,
    parameter int NUM_SW = amp_prot_pkg::NUM_SWITCHES
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic WARN_SET_CMP,
    input wire logic WARN_CLR_CMP,
    input wire logic FOLD_CMP,
    input wire logic SHUT_CMP,
    input wire logic LOW_Z_CMP,
    input wire logic CAP_EMPTY_CMP,
    input wire logic [NUM_SW-1:0] OC_CMP,
    input wire logic THERMAL_WARNING_I,
    output logic THERMAL_WARNING_O,
    output logic THERMAL_WARNING_OE_N,
    input wire logic FAULT_INDICATOR_I,
    output logic FAULT_INDICATOR_O,
    output logic FAULT_INDICATOR_OE_N,
    output logic SWITCH_EN,
    output logic AUDIO_EN,
    output logic [3:0] GAIN_ATTEN,
    output logic [NUM_SW-1:0] CURRENT_LIMIT,
    output logic PROT_DISCHARGE
);
    localparam int SYNC_N = amp_prot_pkg::IX_OC + NUM_SW;
    localparam int TW = amp_prot_pkg::TMR_W;
    localparam int PW = amp_prot_pkg::PH_W;
    localparam logic [TW-1:0] RESTART_LAST = TW'(RESTART_CYCLES - 1);
    localparam logic [TW-1:0] STEP_LAST = TW'(FOLD_STEP_CYCLES - 1);
    localparam logic [PW-1:0] PHASE_LAST = PW'(CARRIER_CYCLES - 1);
    localparam logic [PW-1:0] PHASE_HALF = PW'(CARRIER_CYCLES / 2);

    typedef struct packed {
        logic [SYNC_N-1:0] s1;
        logic [SYNC_N-1:0] s2;
        logic [SYNC_N-1:0] s3;
        logic [SYNC_N-1:0] filt;
        amp_prot_pkg::fsm_t state;
        logic [TW-1:0] tmr;
        logic [TW-1:0] step_cnt;
        logic [PW-1:0] phase;
        logic [1:0] mode;
        logic fold_dis;
        logic warn;
        logic [3:0] atten;
        logic [NUM_SW-1:0] limit;
        logic discharge;
        logic switch_en;
        logic audio_en;
        logic warn_oe_n;
        logic fault_oe_n;
        logic pin_lvl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    state_t r;
    state_t n;
    logic [SYNC_N-1:0] async_in;
    logic [SYNC_N-1:0] filt_nxt;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic apb_wr;
    logic mode_on;
    logic switching;
    logic cyc_start;
    logic step_tick;
    logic fold_on;
    logic fault_pulse;

    assign async_in = {OC_CMP, FAULT_INDICATOR_I, THERMAL_WARNING_I,
        CAP_EMPTY_CMP, LOW_Z_CMP, SHUT_CMP, FOLD_CMP, WARN_CLR_CMP,
        WARN_SET_CMP};

    // A change is accepted once the second and third stages agree.
    for (genvar i = 0; i < SYNC_N; i++) begin : g_filt
        assign filt_nxt[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.filt[i];
    end

    assign mode_on = (r.mode == amp_prot_pkg::MODE_MUTE) ||
        (r.mode == amp_prot_pkg::MODE_OPERATE);
    assign switching = (r.state == amp_prot_pkg::ST_RUN);
    assign cyc_start = (r.phase == PHASE_LAST);
    assign step_tick = (r.step_cnt == STEP_LAST);
    assign fold_on = r.filt[amp_prot_pkg::IX_FOLD] && !r.fold_dis;
    assign apb_wr = PSEL && PENABLE && r.pready && PWRITE && !r.pslverr;

    always_comb begin
        ctrl_word = '0;
        ctrl_word[amp_prot_pkg::CTRL_MODE_LSB +: 2] = r.mode;
        ctrl_word[amp_prot_pkg::CTRL_FOLD_DIS] = r.fold_dis;
        status_word = '0;
        status_word[amp_prot_pkg::STAT_STATE_LSB +: 3] = r.state;
        status_word[amp_prot_pkg::STAT_WARN] = r.warn;
        status_word[amp_prot_pkg::STAT_FOLD] = fold_on;
        status_word[amp_prot_pkg::STAT_LIMIT] = |r.limit;
        status_word[amp_prot_pkg::STAT_DISCH] = r.discharge;
        status_word[amp_prot_pkg::STAT_ATTEN_LSB +: 4] = r.atten;
        status_word[amp_prot_pkg::STAT_WPIN] = r.filt[amp_prot_pkg::IX_WPIN];
        status_word[amp_prot_pkg::STAT_FPIN] = r.filt[amp_prot_pkg::IX_FPIN];
    end

    always_comb begin
        n = r;
        n.s1 = async_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.filt = filt_nxt;
        // Answer is prepared in the setup cycle so the access phase is ready.
        n.pready = PSEL && !PENABLE;
        if (PSEL && !PENABLE) begin
            n.pslverr = 1'b0;
            n.prdata = '0;
            if (PADDR == amp_prot_pkg::ADDR_CTRL) begin
                n.prdata = ctrl_word;
            end else if (PADDR == amp_prot_pkg::ADDR_STATUS) begin
                n.prdata = status_word;
            end else begin
                n.pslverr = 1'b1;
            end
        end
        if (apb_wr && PADDR == amp_prot_pkg::ADDR_CTRL) begin
            n.mode = PWDATA[amp_prot_pkg::CTRL_MODE_LSB +: 2];
            n.fold_dis = PWDATA[amp_prot_pkg::CTRL_FOLD_DIS];
        end
        n.phase = cyc_start ? '0 : r.phase + 1'b1;
        n.step_cnt = step_tick ? '0 : r.step_cnt + 1'b1;
        // Warning has its own set and reset levels and ignores the mode.
        if (r.filt[amp_prot_pkg::IX_WSET]) begin
            n.warn = 1'b1;
        end else if (r.filt[amp_prot_pkg::IX_WCLR]) begin
            n.warn = 1'b0;
        end
        // A new overcurrent event wins over the end-of-cycle release.
        for (int i = 0; i < NUM_SW; i++) begin
            if (switching && r.filt[amp_prot_pkg::IX_OC + i]) begin
                n.limit[i] = 1'b1;
            end else if (cyc_start || !switching) begin
                n.limit[i] = 1'b0;
            end
        end
        n.discharge = switching && (|r.limit) &&
            r.filt[amp_prot_pkg::IX_LOWZ];
        if (r.fold_dis) begin
            n.atten = amp_prot_pkg::ATTEN_ZERO;
        end else if (r.filt[amp_prot_pkg::IX_SHUT]) begin
            n.atten = amp_prot_pkg::ATTEN_MAX;
        end else if (step_tick && fold_on &&
            r.atten != amp_prot_pkg::ATTEN_MAX) begin
            n.atten = r.atten + 4'h1;
        end else if (step_tick && !fold_on &&
            r.atten != amp_prot_pkg::ATTEN_ZERO) begin
            n.atten = r.atten - 4'h1;
        end
        case (r.state)
            amp_prot_pkg::ST_STANDBY: begin
                n.tmr = '0;
                n.state = amp_prot_pkg::ST_STARTUP;
            end
            amp_prot_pkg::ST_STARTUP: begin
                n.tmr = r.tmr + 1'b1;
                if (r.tmr == RESTART_LAST) begin
                    n.tmr = '0;
                    n.state = amp_prot_pkg::ST_RUN;
                end
            end
            amp_prot_pkg::ST_RUN: begin
                n.tmr = '0;
                if (r.filt[amp_prot_pkg::IX_SHUT]) begin
                    n.state = amp_prot_pkg::ST_OT_OFF;
                end else if (r.discharge &&
                    r.filt[amp_prot_pkg::IX_CAPE]) begin
                    n.state = amp_prot_pkg::ST_OC_OFF;
                end
            end
            amp_prot_pkg::ST_OT_OFF: begin
                n.tmr = r.tmr + 1'b1;
                if (r.filt[amp_prot_pkg::IX_SHUT]) begin
                    n.tmr = '0;
                end else if (r.tmr == RESTART_LAST) begin
                    n.tmr = '0;
                    n.state = amp_prot_pkg::ST_RUN;
                end
            end
            amp_prot_pkg::ST_OC_OFF: begin
                n.tmr = r.tmr + 1'b1;
                if (r.tmr == RESTART_LAST) begin
                    n.tmr = '0;
                    n.state = amp_prot_pkg::ST_RUN;
                end
            end
            default: begin
                n.tmr = '0;
                n.state = amp_prot_pkg::ST_STANDBY;
            end
        endcase
        if (!mode_on) begin
            n.tmr = '0;
            n.state = amp_prot_pkg::ST_STANDBY;
        end
        n.switch_en = (n.state == amp_prot_pkg::ST_RUN);
        n.audio_en = n.switch_en &&
            (n.mode == amp_prot_pkg::MODE_OPERATE);
        n.warn_oe_n = !n.warn;
        fault_pulse = (|n.limit) && (n.phase < PHASE_HALF);
        // Off states already last at least one restart interval.
        n.fault_oe_n = !((n.state == amp_prot_pkg::ST_STARTUP) ||
            (n.state == amp_prot_pkg::ST_OT_OFF) ||
            (n.state == amp_prot_pkg::ST_OC_OFF) ||
            fault_pulse);
        n.pin_lvl = 1'b0;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            r <= '0;
            r.warn_oe_n <= 1'b1;
            r.fault_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign PRDATA = r.prdata;
    assign PREADY = r.pready;
    assign PSLVERR = r.pslverr;
    assign THERMAL_WARNING_O = r.pin_lvl;
    assign THERMAL_WARNING_OE_N = r.warn_oe_n;
    assign FAULT_INDICATOR_O = r.pin_lvl;
    assign FAULT_INDICATOR_OE_N = r.fault_oe_n;
    assign SWITCH_EN = r.switch_en;
    assign AUDIO_EN = r.audio_en;
    assign GAIN_ATTEN = r.atten;
    assign CURRENT_LIMIT = r.limit;
    assign PROT_DISCHARGE = r.discharge;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence cap_trip_s;
        switching && mode_on && r.discharge &&
            r.filt[amp_prot_pkg::IX_CAPE] && !r.filt[amp_prot_pkg::IX_SHUT];
    endsequence
    sequence held_off_s;
        !SWITCH_EN && !FAULT_INDICATOR_OE_N;
    endsequence

    warn_assert_a: assert property (
        r.filt[amp_prot_pkg::IX_WSET] |=> !THERMAL_WARNING_OE_N)
        else $error("warning pin not pulled low");
    warn_hold_a: assert property (
        (!THERMAL_WARNING_OE_N && !r.filt[amp_prot_pkg::IX_WCLR])
        |=> !THERMAL_WARNING_OE_N)
        else $error("warning pin released above reset level");
    atten_max_a: assert property (
        (r.filt[amp_prot_pkg::IX_SHUT] && !r.fold_dis)
        |=> GAIN_ATTEN == amp_prot_pkg::ATTEN_MAX)
        else $error("gain not reduced fully at shutdown level");
    fold_off_a: assert property (
        r.fold_dis |=> GAIN_ATTEN == amp_prot_pkg::ATTEN_ZERO)
        else $error("gain reduced while foldback disabled");
    warn_indep_a: assert property (
        (r.fold_dis && $rose(r.filt[amp_prot_pkg::IX_WSET]))
        |=> !THERMAL_WARNING_OE_N)
        else $error("warning lost with foldback disabled");
    ot_stop_a: assert property (
        (switching && mode_on && r.filt[amp_prot_pkg::IX_SHUT])
        |=> !SWITCH_EN ##1 held_off_s)
        else $error("switching not stopped at overtemperature");
    limit_set_a: assert property (
        (switching && r.filt[amp_prot_pkg::IX_OC]) |=> CURRENT_LIMIT[0])
        else $error("overcurrent did not force current limit");
    soft_limit_a: assert property (
        (switching && mode_on && !r.discharge &&
        !r.filt[amp_prot_pkg::IX_SHUT]) |=> SWITCH_EN)
        else $error("switching stopped on high impedance limit");
    oc_trip_a: assert property (
        cap_trip_s |=> held_off_s[*3])
        else $error("empty capacitor did not shut down");
    start_fault_a: assert property (
        (r.state == amp_prot_pkg::ST_STARTUP) |-> held_off_s)
        else $error("fault pin idle during start-up");
    oc_fault_a: assert property (
        (r.state == amp_prot_pkg::ST_OC_OFF) |-> !FAULT_INDICATOR_OE_N)
        else $error("fault pin released during overcurrent off");
    apb_ready_a: assert property (
        (PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
        else $error("bus answer not one cycle after setup");
    warn_release_a: assert property (
        (r.filt[amp_prot_pkg::IX_WCLR] && !r.filt[amp_prot_pkg::IX_WSET])
        |=> THERMAL_WARNING_OE_N)
        else $error("warning pin held below reset level");
    fold_ramp_a: assert property (
        (step_tick && fold_on && !r.filt[amp_prot_pkg::IX_SHUT] &&
        r.atten != amp_prot_pkg::ATTEN_MAX)
        |=> GAIN_ATTEN == $past(GAIN_ATTEN) + 4'h1)
        else $error("gain not stepped down in foldback range");
    ot_hold_a: assert property (
        (r.state == amp_prot_pkg::ST_OT_OFF && mode_on &&
        r.filt[amp_prot_pkg::IX_SHUT]) |=> !SWITCH_EN)
        else $error("switching resumed above shutdown level");
    limit_clear_a: assert property (
        (cyc_start && !r.filt[amp_prot_pkg::IX_OC]) |=> !CURRENT_LIMIT[0])
        else $error("current limit kept past the switching cycle");
    standby_off_a: assert property (
        !mode_on |=> (!SWITCH_EN && !AUDIO_EN))
        else $error("amplifier running in standby");
endmodule // amp_prot_seq

// >>> amp_prot_host.sv
// Host-side pull-ups for the two diagnostic pins and a falling-edge watcher for the fault pin.
`timescale 1ns/100ps
module amp_prot_host (
    input wire logic clk,
    input wire logic warn_o,
    input wire logic warn_oe_n,
    input wire logic fault_o,
    input wire logic fault_oe_n,
    output logic warn_pin,
    output logic fault_pin,
    output int fault_falls
);
    logic fault_q = 1'b1;
    int cnt = 0;
    // A released pin is pulled up to the high level.
    assign warn_pin = warn_oe_n ? 1'b1 : warn_o;
    assign fault_pin = fault_oe_n ? 1'b1 : fault_o;
    assign fault_falls = cnt;
    always @(posedge clk) begin
        fault_q <= fault_pin;
        if (fault_q === 1'b1 && fault_pin === 1'b0) begin
            cnt <= cnt + 1;
        end
    end
endmodule // amp_prot_host

// >>> testbench.sv
// Self-checking bench for the amplifier protection sequencer.
`timescale 1ns/100ps
module testbench;
    localparam int RST = 200;
    localparam int CAR = 16;
    logic CORE_CLK = 1'b0, RST_N = 1'b0;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, err, WARN_SET_CMP = 1'b0, WARN_CLR_CMP = 1'b1;
    logic FOLD_CMP = 1'b0, SHUT_CMP = 1'b0, LOW_Z_CMP = 1'b0;
    logic CAP_EMPTY_CMP = 1'b0, THERMAL_WARNING_I, FAULT_INDICATOR_I;
    logic [3:0] OC_CMP = 4'h0, GAIN_ATTEN, CURRENT_LIMIT, got;
    logic THERMAL_WARNING_O, THERMAL_WARNING_OE_N, FAULT_INDICATOR_O;
    logic FAULT_INDICATOR_OE_N, SWITCH_EN, AUDIO_EN, PROT_DISCHARGE;
    int miscompares = 0, num_checks = 0, cycles = 0, seed = 15;
    int n, g, f0, idx, k, ofs;
    amp_prot_seq #(.RESTART_CYCLES(RST), .FOLD_STEP_CYCLES(4),
        .CARRIER_CYCLES(CAR), .NUM_SW(4)) i_amp_prot_seq (
        .CORE_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .WARN_SET_CMP, .WARN_CLR_CMP,
        .FOLD_CMP, .SHUT_CMP, .LOW_Z_CMP, .CAP_EMPTY_CMP, .OC_CMP,
        .THERMAL_WARNING_I, .THERMAL_WARNING_O, .THERMAL_WARNING_OE_N,
        .FAULT_INDICATOR_I, .FAULT_INDICATOR_O, .FAULT_INDICATOR_OE_N,
        .SWITCH_EN, .AUDIO_EN, .GAIN_ATTEN, .CURRENT_LIMIT,
        .PROT_DISCHARGE);
    amp_prot_host i_amp_prot_host (.clk(CORE_CLK),
        .warn_o(THERMAL_WARNING_O), .warn_oe_n(THERMAL_WARNING_OE_N),
        .fault_o(FAULT_INDICATOR_O), .fault_oe_n(FAULT_INDICATOR_OE_N),
        .warn_pin(THERMAL_WARNING_I), .fault_pin(FAULT_INDICATOR_I),
        .fault_falls(f0));
    always #4 CORE_CLK = ~CORE_CLK;
    function automatic logic [3:0] lim_mask(input int i);
        return 4'(1 << i);
    endfunction
    task automatic conclude();
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge CORE_CLK);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int t;
        t = 0;
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        @(posedge CORE_CLK);
        while (PREADY !== 1'b1) begin
            t++;
            @(posedge CORE_CLK);
        end
        chk("pready waits", 32'h0, 32'(t));
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // Waits for the switching enable to reach a level; counts off cycles
    // in which the fault pin was not held low.
    task automatic wait_sw(input logic lvl);
        n = 0;
        g = 0;
        while (SWITCH_EN !== lvl && n < 600) begin
            @(posedge CORE_CLK);
            n++;
            if (SWITCH_EN === 1'b0 && FAULT_INDICATOR_I !== 1'b0) g++;
        end
    endtask
    initial begin
        cyc(16);
        RST_N <= 1'b1;
        chk("warn oe_n", 32'h1, 32'(THERMAL_WARNING_OE_N));
        chk("fault oe_n", 32'h1, 32'(FAULT_INDICATOR_OE_N));
        apb(1'b0, amp_prot_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        apb(1'b1, amp_prot_pkg::ADDR_CTRL, 32'($random(seed)) & ~32'h7);
        apb(1'b0, amp_prot_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl rw", 32'h0, rd);
        apb(1'b1, amp_prot_pkg::ADDR_CTRL, 32'h2);
        cyc(8);
        chk("startup fault", 32'h0, 32'(FAULT_INDICATOR_I));
        chk("startup off", 32'h0, 32'(SWITCH_EN));
        wait_sw(1'b1);
        chk("startup time", 32'h1, 32'(n > RST - 30 && n < RST + 8));
        chk("startup gaps", 32'h0, 32'(g));
        chk("audio on", 32'h1, 32'(AUDIO_EN));
        apb(1'b0, amp_prot_pkg::ADDR_STATUS, 32'h0);
        chk("state", 32'(amp_prot_pkg::ST_RUN), rd & 32'h7);
        for (k = 0; k < 2; k++) begin
            apb(1'b1, amp_prot_pkg::ADDR_CTRL, 32'h2 | 32'(k << 2));
            WARN_CLR_CMP <= 1'b0;
            WARN_SET_CMP <= 1'b1;
            cyc(8);
            chk("warn set", 32'h0, 32'(THERMAL_WARNING_I));
            WARN_SET_CMP <= 1'b0;
            cyc(8);
            chk("warn held", 32'h0, 32'(THERMAL_WARNING_I));
            WARN_CLR_CMP <= 1'b1;
            cyc(8);
            chk("warn clear", 32'h1, 32'(THERMAL_WARNING_I));
        end
        apb(1'b1, amp_prot_pkg::ADDR_CTRL, 32'h2);
        FOLD_CMP <= 1'b1;
        cyc(10);
        chk("fold ramp", 32'h1, 32'(GAIN_ATTEN > 0 && GAIN_ATTEN < 12));
        cyc(60);
        chk("fold max", 32'(amp_prot_pkg::ATTEN_MAX), 32'(GAIN_ATTEN));
        apb(1'b1, amp_prot_pkg::ADDR_CTRL, 32'h6);
        cyc(4);
        chk("fold off", 32'h0, 32'(GAIN_ATTEN));
        FOLD_CMP <= 1'b0;
        apb(1'b1, amp_prot_pkg::ADDR_CTRL, 32'h2);
        ofs = 32'($random(seed)) & 3;
        for (k = 0; k < 4; k++) begin
            idx = (k + ofs) % 4;
            OC_CMP <= lim_mask(idx);
            n = 0;
            got = 4'h0;
            while (got === 4'h0 && n < 12) begin
                @(posedge CORE_CLK);
                got = CURRENT_LIMIT;
                n++;
            end
            cyc(32'($random(seed)) & 3);
            OC_CMP <= 4'h0;
            chk("limit set", 32'(lim_mask(idx)), 32'(got));
            cyc(2 * CAR + 8);
            chk("limit clear", 32'h0, 32'(CURRENT_LIMIT));
            chk("limit runs", 32'h1, 32'(SWITCH_EN));
        end
        g = f0;
        OC_CMP <= lim_mask(32'($random(seed)) & 3);
        cyc(4 * CAR);
        chk("limit pulses", 32'h1, 32'(f0 - g >= 3));
        chk("clipped run", 32'h1, 32'(SWITCH_EN));
        OC_CMP <= 4'h0;
        SHUT_CMP <= 1'b1;
        cyc(8);
        chk("ot off", 32'h0, 32'(SWITCH_EN));
        chk("ot atten", 32'(amp_prot_pkg::ATTEN_MAX), 32'(GAIN_ATTEN));
        cyc(50);
        SHUT_CMP <= 1'b0;
        wait_sw(1'b1);
        chk("ot restart", 32'h1, 32'(n >= RST && n <= RST + 12));
        chk("ot fault", 32'h0, 32'(g));
        LOW_Z_CMP <= 1'b1;
        OC_CMP <= 4'h1;
        cyc(8);
        chk("discharge", 32'h1, 32'(PROT_DISCHARGE));
        CAP_EMPTY_CMP <= 1'b1;
        wait_sw(1'b0);
        chk("oc trip", 32'h1, 32'(n <= 10));
        wait_sw(1'b1);
        chk("oc retry", 32'h1, 32'(n >= RST - 2 && n <= RST + 4));
        chk("oc fault", 32'h0, 32'(g));
        wait_sw(1'b0);
        chk("oc retrip", 32'h1, 32'(n <= 12));
        OC_CMP <= 4'h0;
        LOW_Z_CMP <= 1'b0;
        CAP_EMPTY_CMP <= 1'b0;
        wait_sw(1'b1);
        chk("oc recover", 32'h1, 32'(n <= RST + 12 && g == 0));
        cyc(2 * RST);
        chk("oc stays on", 32'h1, 32'(SWITCH_EN));
        apb(1'b1, amp_prot_pkg::ADDR_CTRL, 32'h1);
        cyc(4);
        chk("mute audio", 32'h0, 32'(AUDIO_EN));
        chk("mute runs", 32'h1, 32'(SWITCH_EN));
        apb(1'b1, amp_prot_pkg::ADDR_CTRL, 32'h0);
        cyc(4);
        chk("standby", 32'h0, 32'(SWITCH_EN));
        apb(1'b1, amp_prot_pkg::ADDR_CTRL, 32'h2);
        cyc(8);
        chk("restart fault", 32'h0, 32'(FAULT_INDICATOR_I));
        apb(1'b1, amp_prot_pkg::ADDR_CTRL, 32'h3);
        cyc(4);
        chk("spare standby", 32'h1, 32'(FAULT_INDICATOR_I));
        chk("spare off", 32'h0, 32'(SWITCH_EN));
        conclude();
    end
endmodule // testbench
